// *** hw/sbk_bank_decode.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sbk_consts.vh"

module sbk_bank_decode (
    input  wire [7:0] i_addr,
    input  wire       i_indirect,
    input  wire [7:0] i_status,
    output wire [8:0] o_full_addr,
    output wire [8:0] o_bank_base,
    output wire       o_sel_status,
    output wire       o_sel_pchold,
    output wire       o_sel_irqctl,
    output wire       o_sel_pie,
    output wire       o_sel_rcau,
    output wire       o_sel_adcfg,
    output wire       o_hit
);

    // ****************************************
    // address forming
    // ****************************************
    wire [1:0] bank;
    wire [6:0] low;
    wire       lower_pair;

    // direct: bank bits from status, indirect: pointer plus bank-pair bit
    assign o_full_addr = i_indirect ? {i_status[`SBK_ST_IBANK], i_addr}
                       : {i_status[`SBK_ST_RPH], i_status[`SBK_ST_RPL], i_addr[6:0]};
    assign bank        = o_full_addr[8:7];
    assign low         = o_full_addr[6:0];
    assign o_bank_base = {bank, 7'h00}; // each bank spans 128 bytes
    assign lower_pair  = (bank[1] == 1'b0);

    // ****************************************
    // register selects
    // ****************************************
    // mirrored registers answer in bank 0 and bank 1 alike
    assign o_sel_status = lower_pair && (low == `SBK_LOW_STATUS);
    assign o_sel_pchold = lower_pair && (low == `SBK_LOW_PCHOLD);
    assign o_sel_irqctl = lower_pair && (low == `SBK_LOW_IRQCTL);
    // bank-1 only registers
    assign o_sel_pie    = (bank == `SBK_BANK1) && (low == `SBK_LOW_PIE);
    assign o_sel_rcau   = (bank == `SBK_BANK1) && (low == `SBK_LOW_RCAU);
    assign o_sel_adcfg  = (bank == `SBK_BANK1) && (low == `SBK_LOW_ADCFG);
    assign o_hit = o_sel_status | o_sel_pchold | o_sel_irqctl | o_sel_pie | o_sel_rcau | o_sel_adcfg;

endmodule

`default_nettype wire

// *** hw/sbk_consts.vh ***
`ifndef SBK_CONSTS_VH
`define SBK_CONSTS_VH

// ****************************************
// register locations, low seven address bits
// ****************************************
`define SBK_LOW_STATUS      7'h03
`define SBK_LOW_PCHOLD      7'h0a
`define SBK_LOW_IRQCTL      7'h0b
`define SBK_LOW_PIE         7'h0c
`define SBK_LOW_RCAU        7'h0e
`define SBK_LOW_ADCFG       7'h1f
`define SBK_BANK1           2'h1

// ****************************************
// printed bank-1 offsets
// ****************************************
`define SBK_OFF_IRQCTL      8'h8b
`define SBK_OFF_PIE         8'h8c
`define SBK_OFF_RCAU        8'h8e
`define SBK_OFF_ADCFG       8'h9f

// ****************************************
// status field positions
// ****************************************
`define SBK_ST_IBANK        7
`define SBK_ST_RPH          6
`define SBK_ST_RPL          5
`define SBK_ST_TMO          4
`define SBK_ST_PWDN         3
`define SBK_ST_Z            2
`define SBK_ST_DCY          1
`define SBK_ST_C            0

// ****************************************
// other field positions
// ****************************************
`define SBK_IC_PORT_FLAG    0
`define SBK_IC_EXT_FLAG     1
`define SBK_IC_TMR_FLAG     2
`define SBK_PIE_CDON        6
`define SBK_PC_PCHK         7
`define SBK_PC_PARF         2
`define SBK_PC_POR          1
`define SBK_PC_BRNF         0

// ****************************************
// reset values and bank size
// ****************************************
`define SBK_RST_STATUS      8'h18
`define SBK_RST_IRQCTL      8'h00
`define SBK_RST_PIE         1'h0
`define SBK_RST_ADCFG       2'h0
`define SBK_RST_PCHOLD      5'h00
`define SBK_RST_PCHK        1'h0
`define SBK_RST_PARF        1'h1
`define SBK_RST_POR         1'h0
`define SBK_RST_BRNF        1'h0
`define SBK_BANK_BYTES      9'h080

`endif

// *** hw/sbk_regs.v ***
// Summary of operation
// - flag-updating instruction on status blocks writes to z, dc, c; alu sets them.
// - instruction writes never change timeout and power-down flags.
// - clearing status clears upper three bits, sets zero, keeps the rest.
// - on subtraction carry is inverted borrow, digit carry inverted digit borrow.
// - interrupt control reached at the same register from bank 0 and bank 1.
// - pc upper bits only via holding register, copied when the counter loads.
// - power-on clears interrupt control; other resets clear upper seven, keep bit 0.
// - unimplemented addresses and bits read as zero.
// - status accepts any instruction; unprotected bits take the result.
// - direct bank bits 00..11 select banks 0..3, 128 bytes each.
`timescale 1ns/1ps
`default_nettype none
`include "sbk_consts.vh"

module sbk_regs (
    input  wire       i_core_clk,
    input  wire       i_reset,
    input  wire       i_ext_reset,
    input  wire       i_wdt_reset,
    input  wire       i_brownout_reset,
    input  wire       i_parity_reset,
    input  wire [7:0] i_addr,
    input  wire       i_indirect,
    input  wire       i_rd_en,
    input  wire       i_wr_en,
    input  wire [7:0] i_wr_data,
    input  wire       i_flag_upd,
    input  wire [2:0] i_flag_sel,
    input  wire       i_alu_zero,
    input  wire       i_alu_dcarry,
    input  wire       i_alu_carry,
    input  wire       i_alu_sub,
    input  wire       i_sleep,
    input  wire       i_clrwdt,
    input  wire       i_tmr_ovf,
    input  wire       i_ext_edge,
    input  wire       i_port_change,
    input  wire       i_pc_load,
    output reg  [7:0] o_rd_data,
    output reg        o_rd_hit,
    output wire [7:0] o_status,
    output wire [8:0] o_full_addr,
    output wire [8:0] o_bank_base,
    output reg  [7:0] o_interrupt_control,
    output reg        o_conversion_done_irq_enable,
    output reg        o_parity_check_enable,
    output reg  [1:0] o_analog_config,
    output reg  [4:0] o_pc_high_holding_reg,
    output reg  [4:0] o_pc_upper
);

    // ****************************************
    // declarations
    // ****************************************
    wire       sel_status;
    wire       sel_pchold;
    wire       sel_irqctl;
    wire       sel_pie;
    wire       sel_rcau;
    wire       sel_adcfg;
    wire       hit;
    wire       other_reset;
    wire       wr_irqctl;
    reg        parity_reset_flag;
    reg        power_on_flag;
    reg        brownout_reset_flag;
    reg  [7:0] next_interrupt_control;
    reg  [7:0] next_rd_data;
    reg  [7:0] rcau_view;

    // external-pin and watchdog resets are the non power-up resets
    assign other_reset = i_ext_reset | i_wdt_reset;
    assign wr_irqctl   = i_wr_en & sel_irqctl;

    // ****************************************
    // bank and address decode
    // ****************************************
    // one decode serves both the read and the write of an instruction
    sbk_bank_decode u_decode (
        .i_addr       (i_addr),
        .i_indirect   (i_indirect),
        .i_status     (o_status),
        .o_full_addr  (o_full_addr),
        .o_bank_base  (o_bank_base),
        .o_sel_status (sel_status),
        .o_sel_pchold (sel_pchold),
        .o_sel_irqctl (sel_irqctl),
        .o_sel_pie    (sel_pie),
        .o_sel_rcau   (sel_rcau),
        .o_sel_adcfg  (sel_adcfg),
        .o_hit        (hit)
    );

    // ****************************************
    // arithmetic and reset status
    // ****************************************
    // clearing the status register arrives as a zero write with
    // only the zero flag updated, which yields 000u u1uu
    sbk_status_reg u_status (
        .i_core_clk    (i_core_clk),
        .i_reset       (i_reset),
        .i_other_reset (other_reset),
        .i_wdt_reset   (i_wdt_reset),
        .i_wr_en       (i_wr_en & sel_status),
        .i_wr_data     (i_wr_data),
        .i_flag_upd    (i_flag_upd),
        .i_flag_sel    (i_flag_sel),
        .i_alu_zero    (i_alu_zero),
        .i_alu_dcarry  (i_alu_dcarry),
        .i_alu_carry   (i_alu_carry),
        .i_alu_sub     (i_alu_sub),
        .i_sleep       (i_sleep),
        .i_clrwdt      (i_clrwdt),
        .o_status      (o_status)
    );

    // ****************************************
    // interrupt control
    // ****************************************
    // hardware event flags: a set in the clearing cycle wins
    always @* begin
        next_interrupt_control = o_interrupt_control;
        if (wr_irqctl) begin
            next_interrupt_control = i_wr_data;
        end
        if (i_tmr_ovf) begin
            next_interrupt_control[`SBK_IC_TMR_FLAG] = 1'b1;
        end
        if (i_ext_edge) begin
            next_interrupt_control[`SBK_IC_EXT_FLAG] = 1'b1;
        end
        if (i_port_change) begin
            next_interrupt_control[`SBK_IC_PORT_FLAG] = 1'b1;
        end
        // non power-up reset clears upper seven bits, bit 0 kept
        if (other_reset) begin
            next_interrupt_control[7:1] = 7'h00;
        end
    end

    // power-on value taken on the asynchronous reset
    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_interrupt_control <= `SBK_RST_IRQCTL;
        end else begin
            o_interrupt_control <= next_interrupt_control;
        end
    end

    // ****************************************
    // peripheral enable and analog pin configuration
    // ****************************************
    // both are cleared by power-on, external-pin and watchdog resets
    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_conversion_done_irq_enable <= `SBK_RST_PIE;
            o_analog_config              <= `SBK_RST_ADCFG;
        end else if (other_reset) begin
            o_conversion_done_irq_enable <= `SBK_RST_PIE;
            o_analog_config              <= `SBK_RST_ADCFG;
        end else begin
            if (i_wr_en && sel_pie) begin
                o_conversion_done_irq_enable <= i_wr_data[`SBK_PIE_CDON];
            end
            if (i_wr_en && sel_adcfg) begin
                o_analog_config <= i_wr_data[1:0];
            end
        end
    end

    // ****************************************
    // power and reset cause
    // ****************************************
    // hardware clears the cause flag of its reset; software sets them again
    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_parity_check_enable <= `SBK_RST_PCHK;
            parity_reset_flag     <= `SBK_RST_PARF;
            power_on_flag         <= `SBK_RST_POR;
            brownout_reset_flag   <= `SBK_RST_BRNF;
        end else begin
            if (i_wr_en && sel_rcau) begin
                o_parity_check_enable <= i_wr_data[`SBK_PC_PCHK];
                parity_reset_flag     <= i_wr_data[`SBK_PC_PARF];
                power_on_flag         <= i_wr_data[`SBK_PC_POR];
                brownout_reset_flag   <= i_wr_data[`SBK_PC_BRNF];
            end
            // a reset event wins over a software write in the same cycle
            if (i_parity_reset) begin
                parity_reset_flag <= 1'b0;
            end
            if (i_brownout_reset) begin
                brownout_reset_flag <= 1'b0;
            end
        end
    end

    // ****************************************
    // program counter high byte
    // ****************************************
    // holding register is the only way to the upper counter bits
    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pc_high_holding_reg <= `SBK_RST_PCHOLD;
            o_pc_upper            <= `SBK_RST_PCHOLD;
        end else if (other_reset) begin
            o_pc_high_holding_reg <= `SBK_RST_PCHOLD;
            o_pc_upper            <= `SBK_RST_PCHOLD;
        end else begin
            if (i_wr_en && sel_pchold) begin
                o_pc_high_holding_reg <= i_wr_data[4:0];
            end
            if (i_pc_load) begin
                o_pc_upper <= o_pc_high_holding_reg;
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // reset-cause register view with empty bits at zero
    always @* begin
        rcau_view = 8'h00;
        rcau_view[`SBK_PC_PCHK] = o_parity_check_enable;
        rcau_view[`SBK_PC_PARF] = parity_reset_flag;
        rcau_view[`SBK_PC_POR]  = power_on_flag;
        rcau_view[`SBK_PC_BRNF] = brownout_reset_flag;
    end

    // read multiplexer; misses and empty bits give zero
    always @* begin
        next_rd_data = 8'h00;
        if (sel_status) begin
            next_rd_data = o_status;
        end else if (sel_pchold) begin
            next_rd_data = {3'h0, o_pc_high_holding_reg};
        end else if (sel_irqctl) begin
            next_rd_data = o_interrupt_control;
        end else if (sel_pie) begin
            next_rd_data[`SBK_PIE_CDON] = o_conversion_done_irq_enable;
        end else if (sel_rcau) begin
            next_rd_data = rcau_view;
        end else if (sel_adcfg) begin
            next_rd_data = {6'h00, o_analog_config};
        end
    end

    // read data registered; zero when no read is made
    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rd_data <= 8'h00;
            o_rd_hit  <= 1'b0;
        end else if (i_rd_en) begin
            o_rd_data <= next_rd_data;
            o_rd_hit  <= hit;
        end else begin
            o_rd_data <= 8'h00;
            o_rd_hit  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** hw/sbk_status_reg.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sbk_consts.vh"

module sbk_status_reg (
    input  wire       i_core_clk,
    input  wire       i_reset,
    input  wire       i_other_reset,
    input  wire       i_wdt_reset,
    input  wire       i_wr_en,
    input  wire [7:0] i_wr_data,
    input  wire       i_flag_upd,
    input  wire [2:0] i_flag_sel,
    input  wire       i_alu_zero,
    input  wire       i_alu_dcarry,
    input  wire       i_alu_carry,
    input  wire       i_alu_sub,
    input  wire       i_sleep,
    input  wire       i_clrwdt,
    output reg  [7:0] o_status
);

    reg [7:0] next_status;

    // ****************************************
    // one-cycle merge of write, alu flags and reset flags
    // ****************************************
    always @* begin
        next_status = o_status;
        if (i_wr_en) begin
            next_status[7:5] = i_wr_data[7:5];
            if (!i_flag_upd) begin
                next_status[2:0] = i_wr_data[2:0];
            end
        end
        // flag-updating instruction owns z, dc, c; write to them dropped
        if (i_flag_upd) begin
            if (i_flag_sel[2]) begin
                next_status[`SBK_ST_Z] = i_alu_zero;
            end
            if (i_flag_sel[1]) begin
                next_status[`SBK_ST_DCY] = i_alu_sub ? ~i_alu_dcarry : i_alu_dcarry;
            end
            if (i_flag_sel[0]) begin
                next_status[`SBK_ST_C] = i_alu_sub ? ~i_alu_carry : i_alu_carry;
            end
        end
        // timeout and power-down only follow sleep and watchdog logic
        if (i_clrwdt) begin
            next_status[`SBK_ST_TMO]  = 1'b1;
            next_status[`SBK_ST_PWDN] = 1'b1;
        end else if (i_sleep) begin
            next_status[`SBK_ST_TMO]  = 1'b1;
            next_status[`SBK_ST_PWDN] = 1'b0;
        end
        if (i_wdt_reset) begin
            next_status[`SBK_ST_TMO] = 1'b0;
        end
        if (i_other_reset) begin
            next_status[7:5] = 3'h0;
        end
    end

    // protected bits resolved in the same cycle as the write
    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_status <= `SBK_RST_STATUS;
        end else begin
            o_status <= next_status;
        end
    end

endmodule

`default_nettype wire

// *** tb/sbk_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// core side: register accesses, alu flags, events
// ****************************************
module sbk_core_model (
    input wire logic clk
);
    logic [7:0] addr  = 8'h00;
    logic       ind   = 1'b0;
    logic       rd    = 1'b0;
    logic       wr    = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] f     = 8'h00;   // upd, sel z dc c, z, dc, c, sub
    logic [9:0] ev    = 10'h000; // sleep clrwdt tmr ext port pcld extrst wdt brownout parity
    // one instruction access; flags ride with its write
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] fl,
                       input logic i);
        @(posedge clk);
        wr    <= w;
        rd    <= !w;
        addr  <= a;
        wdata <= d;
        f     <= fl;
        ind   <= i;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b0;
        f     <= 8'h00;
        wdata <= ~d;  // released data never shows the last value
    endtask
    // one-cycle event pulse
    task automatic pulse(input logic [9:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 10'h000;
    endtask
endmodule

`default_nettype wire

// *** tb/sbk_regs_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// port checker for the register block
// ****************************************
module sbk_regs_asserts (
    input wire logic       i_core_clk,
    input wire logic       i_reset,
    input wire logic       i_ext_reset,
    input wire logic       i_wdt_reset,
    input wire logic [7:0] i_addr,
    input wire logic       i_indirect,
    input wire logic       i_wr_en,
    input wire logic [7:0] i_wr_data,
    input wire logic       i_flag_upd,
    input wire logic [2:0] i_flag_sel,
    input wire logic       i_alu_zero,
    input wire logic       i_alu_dcarry,
    input wire logic       i_alu_carry,
    input wire logic       i_alu_sub,
    input wire logic       i_sleep,
    input wire logic       i_clrwdt,
    input wire logic       i_pc_load,
    input wire logic [7:0] o_rd_data,
    input wire logic       o_rd_hit,
    input wire logic [7:0] o_status,
    input wire logic [8:0] o_full_addr,
    input wire logic [8:0] o_bank_base,
    input wire logic [7:0] o_interrupt_control,
    input wire logic [4:0] o_pc_high_holding_reg,
    input wire logic [4:0] o_pc_upper
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);
    // direct status write, and no reset event in the same cycle
    wire st_wr = i_wr_en && !i_indirect && (i_addr[6:0] == 7'h03) && !o_status[6];
    wire quiet = !i_ext_reset && !i_wdt_reset;

    AST_TMO_PWDN_LOCK: assert property (
        !i_sleep && !i_clrwdt && !i_wdt_reset |=> $stable(o_status[4:3])) else $error("reset flags moved");
    AST_ZERO_ALU: assert property (
        i_flag_upd && i_flag_sel[2] |=> o_status[2] == $past(i_alu_zero)) else $error("zero flag wrong");
    AST_DCY_BORROW: assert property (
        i_flag_upd && i_flag_sel[1] |=> o_status[1] == ($past(i_alu_dcarry) ^ $past(i_alu_sub)))
        else $error("digit carry wrong");
    AST_C_BORROW: assert property (
        i_flag_upd && i_flag_sel[0] |=> o_status[0] == ($past(i_alu_carry) ^ $past(i_alu_sub)))
        else $error("carry wrong");
    AST_STATUS_WRITE: assert property (
        st_wr && !i_flag_upd && quiet |=> o_status[7:5] == $past(i_wr_data[7:5])
        && o_status[2:0] == $past(i_wr_data[2:0])) else $error("status write lost");
    AST_STATUS_CLEAR: assert property (
        st_wr && i_wr_data == 8'h00 && i_flag_upd && i_flag_sel == 3'b100 |=>
        o_status[7:5] == 3'h0 && o_status[1:0] == $past(o_status[1:0])) else $error("status clear wrong");
    AST_PC_COPY: assert property (
        i_pc_load && quiet |=> o_pc_upper == $past(o_pc_high_holding_reg)) else $error("pc upper not loaded");
    AST_PC_HOLD: assert property (
        !i_pc_load && quiet |=> $stable(o_pc_upper)) else $error("pc upper moved");
    AST_IRQCTL_RESET: assert property (
        !quiet |=> o_interrupt_control[7:1] == 7'h00) else $error("interrupt control kept");
    AST_UNMAPPED_ZERO: assert property (
        !o_rd_hit |-> o_rd_data == 8'h00) else $error("read data without hit");
    AST_BANK_DECODE: assert property (
        !i_indirect |-> o_full_addr == {o_status[6:5], i_addr[6:0]} && o_bank_base == {o_status[6:5], 7'h00})
        else $error("bank decode wrong");
endmodule

`default_nettype wire

// *** tb/sbk_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bench for the status and bank-1 registers
// ****************************************
module sbk_regs_tb;
    logic       clk     = 1'b0;
    logic       rst     = 1'b1;
    int         n_fail  = 0;
    int         n_tests = 0;
    int         cyc     = 0;
    logic [7:0] st      = 8'h18;
    logic [7:0] d;
    logic [7:0] fl;
    logic [7:0] rd_v;
    logic       hit_v;
    logic [7:0] ra [6]  = '{8'h8b, 8'h8c, 8'h8e, 8'h9f, 8'h8d, 8'h90};
    logic [7:0] rv [6]  = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
    logic [7:0] rm [4]  = '{8'hff, 8'h40, 8'h87, 8'h03};
    logic [7:0] pv      = 8'h00;

    sbk_core_model core_u (.clk(clk));
    sbk_regs dut_u (
        .i_core_clk(clk), .i_reset(rst), .i_ext_reset(core_u.ev[6]), .i_wdt_reset(core_u.ev[7]),
        .i_brownout_reset(core_u.ev[8]), .i_parity_reset(core_u.ev[9]), .i_addr(core_u.addr),
        .i_indirect(core_u.ind), .i_rd_en(core_u.rd), .i_wr_en(core_u.wr), .i_wr_data(core_u.wdata),
        .i_flag_upd(core_u.f[7]), .i_flag_sel(core_u.f[6:4]), .i_alu_zero(core_u.f[3]),
        .i_alu_dcarry(core_u.f[2]), .i_alu_carry(core_u.f[1]), .i_alu_sub(core_u.f[0]),
        .i_sleep(core_u.ev[0]), .i_clrwdt(core_u.ev[1]), .i_tmr_ovf(core_u.ev[2]),
        .i_ext_edge(core_u.ev[3]), .i_port_change(core_u.ev[4]), .i_pc_load(core_u.ev[5]),
        .o_rd_data(), .o_rd_hit(), .o_status(), .o_full_addr(), .o_bank_base(),
        .o_interrupt_control(), .o_conversion_done_irq_enable(), .o_parity_check_enable(),
        .o_analog_config(), .o_pc_high_holding_reg(), .o_pc_upper()
    );

    // enable and configuration pins gathered into one byte
    wire  [7:0] pins    = {dut_u.o_parity_check_enable, dut_u.o_conversion_done_irq_enable, 4'h0,
                           dut_u.o_analog_config};

    // core clock and run limit
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            close_out();
        end
    end

    // expected status after a write, with alu flags of the same instruction
    function automatic logic [7:0] st_exp(input logic [7:0] o, input logic [7:0] v, input logic [7:0] f);
        st_exp = {v[7:5], o[4:3], f[7] ? o[2:0] : v[2:0]};
        if (f[7] && f[6]) st_exp[2] = f[3];
        if (f[7] && f[5]) st_exp[1] = f[2] ^ f[0];
        if (f[7] && f[4]) st_exp[0] = f[1] ^ f[0];
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] f = 8'h00);
        core_u.acc(1'b1, a, v, f, 1'b0);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic i = 1'b0);
        core_u.acc(1'b0, a, 8'h00, 8'h00, i);
        #1;
        rd_v  = dut_u.o_rd_data;
        hit_v = dut_u.o_rd_hit;
    endtask
    task automatic ev(input logic [9:0] e);
        core_u.pulse(e);
        #1;
    endtask
    // status write, checked against the bench copy
    task automatic stw(input logic [7:0] v, input logic [7:0] f);
        wr(8'h03, v, f);
        st = st_exp(st, v, f);
        chk("status", dut_u.o_status, st);
    endtask
    task automatic close_out;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        void'($urandom(32'h20f7));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("status_rst", dut_u.o_status, 8'h18);
        chk("irqctl_rst", dut_u.o_interrupt_control, 8'h00);
        stw(8'h20, 8'h00);
        chk("bank_base", dut_u.o_bank_base[8:1], 8'h40);
        wr(8'h8d, 8'hff);
        for (int k = 0; k < 6; k++) begin
            rd(ra[k]);
            chk("read", rd_v, rv[k]);
            chk("hit", {7'h00, hit_v}, {7'h00, k < 4});
        end
        $display("test reset_map done");
        for (int k = 0; k < 32; k++) begin
            d = 8'($urandom);
            wr(ra[k % 4], d);
            rd(ra[k % 4]);
            chk("readback", rd_v, d & rm[k % 4]);
            case (k % 4)
                1: pv[6] = d[6];
                2: pv[7] = d[7];
                3: pv[1:0] = d[1:0];
                default: ;
            endcase
            chk("pins", pins, pv);
        end
        $display("test readback done");
        wr(8'h8b, 8'h5a);
        stw(8'h00, 8'h00);
        rd(8'h0b);
        chk("irqctl_bank0", rd_v, 8'h5a);
        rd(8'h8b, 1'b1);
        chk("irqctl_indirect", rd_v, 8'h5a);
        $display("test mirror done");
        for (int k = 0; k < 24; k++) begin
            d  = 8'($urandom) & 8'h1f;
            fl = (k < 8) ? 8'h00 : {1'b1, 7'($urandom)};
            stw(d, fl);
        end
        stw(8'h00, 8'hc8);
        stw(8'h07, 8'hf1);
        $display("test status done");
        ev(10'h001);
        st[4:3] = 2'b10;
        chk("sleep", dut_u.o_status, st);
        ev(10'h002);
        st[4:3] = 2'b11;
        chk("clrwdt", dut_u.o_status, st);
        ev(10'h080);
        st[7:4] = 4'h0;
        chk("wdt", dut_u.o_status, st);
        fl = 8'h00;
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            wr(8'h0a, d);
            chk("pc_hold", {3'h0, dut_u.o_pc_high_holding_reg}, d & 8'h1f);
            chk("pc_wait", {3'h0, dut_u.o_pc_upper}, fl);
            ev(10'h020);
            fl = d & 8'h1f;
            chk("pc_load", {3'h0, dut_u.o_pc_upper}, fl);
        end
        $display("test flags_pc done");
        wr(8'h0b, 8'hf8);
        ev(10'h01c);
        chk("events", dut_u.o_interrupt_control, 8'hff);
        ev(10'h040);
        chk("ext_reset", dut_u.o_interrupt_control, 8'h01);
        chk("ext_status", dut_u.o_status, st);
        stw(8'h20, 8'h00);
        wr(8'h8e, 8'h07);
        ev(10'h100);
        rd(8'h8e);
        chk("brownout", rd_v, 8'h06);
        ev(10'h200);
        rd(8'h8e);
        chk("parity", rd_v, 8'h02);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("status_rst2", dut_u.o_status, 8'h18);
        rd(8'h0b);
        chk("irqctl_rst2", rd_v, 8'h00);
        $display("test resets done");
        close_out();
    end
endmodule

bind sbk_regs sbk_regs_asserts chk_u (.*);

`default_nettype wire
